// File: rtl/ods_regs.svh
`ifndef ODS_REGS_SVH
`define ODS_REGS_SVH
// register byte addresses on the bus
`define ODS_ADR_OUT_BASE 8'h00
`define ODS_ADR_IN_BASE 8'h20
`define ODS_ADR_MODE 8'h40
`define ODS_ADR_CTRL 8'h44
`define ODS_ADR_STAT 8'h48
// control fields and reset value
`define ODS_CTRL_LINK_EN 0
`define ODS_CTRL_SOFT_LOAD 1
`define ODS_CTRL_RESET 32'h0000_0001
// frame layout
`define ODS_FRAME_BITS 5'h10
`define ODS_SEL_LSB 4
`define ODS_MODE_LSB 2
`define ODS_CODE_STEPS 13'h1000
// timing
`define ODS_CLK_NS 50
`define ODS_CS_HIGH_NS 20
`define ODS_CS_HIGH_CYC (((`ODS_CS_HIGH_NS + `ODS_CLK_NS - 1) / `ODS_CLK_NS) < 1 ? 1 : \
   ((`ODS_CS_HIGH_NS + `ODS_CLK_NS - 1) / `ODS_CLK_NS))
`endif

// File: rtl/ods_pkg.sv
package ods_pkg;
   typedef enum logic [3:0] {
      no_action_cmd = 4'b0000,
      cmd_clear = 4'b0001,
      cmd_wr_in1 = 4'b0010,
      cmd_wr_in2 = 4'b0011,
      cmd_wr_in3 = 4'b0100,
      cmd_wr_in4 = 4'b0101,
      cmd_wr_in5 = 4'b0110,
      cmd_wr_in6 = 4'b0111,
      cmd_wr_in7 = 4'b1000,
      cmd_wr_in8 = 4'b1001,
      cmd_thru_lo = 4'b1010,
      cmd_thru_hi = 4'b1011,
      cmd_thru_all = 4'b1100,
      cmd_wr_in_all = 4'b1101,
      cmd_soft_load = 4'b1110,
      cmd_power = 4'b1111
   } ods_cmd_t;

   typedef enum logic [1:0] {
      pwr_active = 2'b00,
      pwr_hiz = 2'b01,
      pwr_gnd_1k = 2'b10,
      pwr_gnd_100k = 2'b11
   } ods_mode_t;

   typedef enum logic [0:0] {
      st_idle = 1'b0,
      st_shift = 1'b1
   } ods_link_st_t;

   typedef struct packed {
      ods_cmd_t command_nibble;
      logic [11:0] code_value;
   } ods_word_t;

   typedef struct packed {
      ods_mode_t mode;
      logic [11:0] code;
   } ods_chan_t;

   // power command select bits {d3,d2} to channel state
   function automatic ods_mode_t ods_mode_from_bits(input logic [1:0] sel);
      ods_mode_t m;
      m = pwr_gnd_100k;
      unique case (sel)
         2'b11: m = pwr_active;
         2'b01: m = pwr_hiz;
         2'b10: m = pwr_gnd_1k;
         2'b00: m = pwr_gnd_100k;
      endcase
      return m;
   endfunction
endpackage

// File: rtl/ods_serial_rx.sv
`timescale 1ns/1ps
`include "ods_regs.svh"
module ods_serial_rx import ods_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic link_en,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic word_valid,
   output ods_word_t word,
   output logic [4:0] bit_cnt
);
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic sclk_q;
   ods_link_st_t state, next_state;
   logic [15:0] shreg, next_shreg;
   logic [4:0] next_bit_cnt;
   logic next_dout, next_valid;
   logic cs_low, fall;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
         sclk_q <= 1'b1;
      end else begin
         sync1 <= {cs_n, din, sclk};
         sync2 <= sync1;
         sclk_q <= sync2[0];
      end
   end

   assign cs_low = ~sync2[2];
   assign fall = sclk_q & ~sync2[0];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bit_cnt = bit_cnt;
      next_dout = dout;
      next_valid = 1'b0;
      unique case (state)
         st_idle: begin
            if (cs_low && link_en) begin
               next_state = st_shift;
               next_bit_cnt = 5'h00;
            end
         end
         st_shift: begin
            if (!cs_low) begin
               next_state = st_idle;
               next_valid = (bit_cnt == `ODS_FRAME_BITS);
            end else if (fall) begin
               next_shreg = {shreg[14:0], sync2[1]};
               next_dout = shreg[15];
               if (bit_cnt != `ODS_FRAME_BITS) begin
                  next_bit_cnt = bit_cnt + 5'h01;
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_idle;
         shreg <= 16'h0000;
         bit_cnt <= 5'h00;
         dout <= 1'b0;
         word_valid <= 1'b0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bit_cnt <= next_bit_cnt;
         dout <= next_dout;
         word_valid <= next_valid;
      end
   end

   assign word = ods_word_t'(shreg);

   ////////////////////////////////////////////////////////////////////////
   sequence seq_edge_in_frame;
      state == st_shift && cs_low && fall;
   endsequence

   a_shift_msb_first: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_edge_in_frame |=> shreg[0] == $past(sync2[1]) && shreg[15:1] == $past(shreg[14:0]))
      else $error("serial bit not shifted in on falling edge");
   a_dout_echo: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_edge_in_frame |=> dout == $past(shreg[15]))
      else $error("data out not updated on falling edge");
   a_short_frame: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == st_shift && !cs_low && bit_cnt < `ODS_FRAME_BITS) |=> !word_valid)
      else $error("partial frame executed");
   a_frame_done: assert property (@(posedge mclk) disable iff (!rst_n)
      word_valid |-> $past(state == st_shift && !cs_low && bit_cnt == `ODS_FRAME_BITS))
      else $error("word acted on without full frame and select high");
endmodule

// File: rtl/ods_wb_regs.sv
`timescale 1ns/1ps
`include "ods_regs.svh"
module ods_wb_regs import ods_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire ods_chan_t chan [8],
   input wire logic [11:0] in_code [8],
   input wire logic [31:0] status,
   output logic link_en,
   output logic soft_load
);
   logic next_ack, next_link_en, next_soft_load, req, wr_ctrl;
   logic [31:0] next_dat;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ODS_ADR_CTRL);

   always_comb begin
      next_ack = req;
      next_link_en = wr_ctrl ? wb_dat_i[`ODS_CTRL_LINK_EN] : link_en;
      next_soft_load = wr_ctrl & wb_dat_i[`ODS_CTRL_SOFT_LOAD];
      next_dat = 32'h0000_0000;
      if (req && !wb_we_i) begin
         if (wb_adr_i < `ODS_ADR_IN_BASE && wb_adr_i[1:0] == 2'h0) begin
            next_dat = {20'h00000, chan[wb_adr_i[4:2]].code};
         end else if (wb_adr_i < `ODS_ADR_MODE && wb_adr_i[1:0] == 2'h0) begin
            next_dat = {20'h00000, in_code[wb_adr_i[4:2]]};
         end else if (wb_adr_i == `ODS_ADR_MODE) begin
            for (int i = 0; i < 8; i++) begin
               next_dat[2*i +: 2] = chan[i].mode;
            end
         end else if (wb_adr_i == `ODS_ADR_CTRL) begin
            next_dat = {31'h0000_0000, link_en};
         end else if (wb_adr_i == `ODS_ADR_STAT) begin
            next_dat = status;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         link_en <= 1'(`ODS_CTRL_RESET);
         soft_load <= 1'b0;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         link_en <= next_link_en;
         soft_load <= next_soft_load;
      end
   end
endmodule

// File: rtl/ods_dac_ctrl.sv
`timescale 1ns/1ps
`include "ods_regs.svh"
// Overview of operation
// - sample data on falling clock in frame
// - shift one bit per falling clock edge
// - sixteen bits, command nibble first, msb first
// - code is unipolar straight binary, 4096 steps
// - act only after sixteen bits and select high
// - input register keeps latest write to it
// - output code register holds applied code
// - copy to outputs by strobe or command
// - low load strobe makes outputs transparent
// - clear input zeroes all, powers channels down
// - data out changes on falling clock edge
// - power-on gives zero codes, 100k pulldown
// - no-op does nothing; clear command resets all
// - commands 2-4 write input registers 1-3
// - commands 5-9 write 4-8; 13 writes all
// - commands 10-12 write through channel groups
// - command 14 loads only selected channels
// - short frame is discarded without action
module ods_dac_ctrl import ods_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   input wire logic load_strobe_n,
   input wire logic async_clear_n,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output ods_chan_t chan [8]
);
   logic [1:0] ld_sync1, ld_sync2;
   logic ld_low, clr_low;
   logic word_valid, link_en, soft_load;
   ods_word_t word;
   logic [4:0] bit_cnt;
   logic [11:0] in_code [8];
   logic [11:0] next_in_code [8];
   logic [11:0] out_code [8];
   logic [11:0] next_out_code [8];
   ods_mode_t mode [8];
   ods_mode_t next_mode [8];
   ods_cmd_t last_cmd, next_last_cmd;
   logic [31:0] status;
   logic clear_all;
   logic [95:0] in_flat, out_flat;
   logic all_down;

   // channel i picked by the select bits of a load or power word
   function automatic logic chan_picked(input logic [11:0] v, input int i);
      return v[`ODS_SEL_LSB + i];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // serial link and register bus
   ods_serial_rx u_rx (
      .mclk(mclk),
      .rst_n(rst_n),
      .link_en(link_en),
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .dout(dout),
      .word_valid(word_valid),
      .word(word),
      .bit_cnt(bit_cnt)
   );

   ods_wb_regs u_regs (
      .mclk(mclk),
      .rst_n(rst_n),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .chan(chan),
      .in_code(in_code),
      .status(status),
      .link_en(link_en),
      .soft_load(soft_load)
   );

   assign status = {23'h000000, last_cmd, bit_cnt};

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers for load strobe and clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ld_sync1 <= 2'h3;
         ld_sync2 <= 2'h3;
      end else begin
         ld_sync1 <= {async_clear_n, load_strobe_n};
         ld_sync2 <= ld_sync1;
      end
   end

   assign ld_low = ~ld_sync2[0];
   assign clr_low = ~ld_sync2[1];
   assign clear_all = clr_low || (word_valid && word.command_nibble == cmd_clear);

   ////////////////////////////////////////////////////////////////////////
   // command decode and double-buffered channel registers
   always_comb begin
      next_in_code = in_code;
      next_out_code = out_code;
      next_mode = mode;
      next_last_cmd = last_cmd;
      if (word_valid) begin
         next_last_cmd = word.command_nibble;
      end
      if (clear_all) begin
         for (int i = 0; i < 8; i++) begin
            next_in_code[i] = 12'h000;
            next_out_code[i] = 12'h000;
            next_mode[i] = pwr_gnd_100k;
         end
      end else begin
         if (word_valid) begin
            unique case (word.command_nibble)
               no_action_cmd, cmd_clear: begin
               end
               cmd_wr_in1, cmd_wr_in2, cmd_wr_in3, cmd_wr_in4,
               cmd_wr_in5, cmd_wr_in6, cmd_wr_in7, cmd_wr_in8: begin
                  next_in_code[3'(word.command_nibble - cmd_wr_in1)] = word.code_value;
               end
               cmd_thru_lo: begin
                  for (int i = 0; i < 4; i++) begin
                     next_in_code[i] = word.code_value;
                     next_out_code[i] = word.code_value;
                  end
               end
               cmd_thru_hi: begin
                  for (int i = 4; i < 8; i++) begin
                     next_in_code[i] = word.code_value;
                     next_out_code[i] = word.code_value;
                  end
               end
               cmd_thru_all: begin
                  for (int i = 0; i < 8; i++) begin
                     next_in_code[i] = word.code_value;
                     next_out_code[i] = word.code_value;
                  end
               end
               cmd_wr_in_all: begin
                  for (int i = 0; i < 8; i++) begin
                     next_in_code[i] = word.code_value;
                  end
               end
               cmd_soft_load: begin
                  for (int i = 0; i < 8; i++) begin
                     if (chan_picked(word.code_value, i)) begin
                        next_out_code[i] = in_code[i];
                     end
                  end
               end
               cmd_power: begin
                  for (int i = 0; i < 8; i++) begin
                     if (chan_picked(word.code_value, i)) begin
                        next_mode[i] = ods_mode_from_bits(
                           word.code_value[`ODS_MODE_LSB +: 2]);
                     end
                  end
               end
            endcase
         end
         // strobe low or software load: outputs follow input registers
         if (ld_low || soft_load) begin
            for (int i = 0; i < 8; i++) begin
               next_out_code[i] = next_in_code[i];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            in_code[i] <= 12'h000;
            out_code[i] <= 12'h000;
            mode[i] <= pwr_gnd_100k;
         end
         last_cmd <= no_action_cmd;
      end else begin
         in_code <= next_in_code;
         out_code <= next_out_code;
         mode <= next_mode;
         last_cmd <= next_last_cmd;
      end
   end

   // code is straight binary, one step per reference / 4096
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         chan[i].code = out_code[i];
         chan[i].mode = mode[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   always_comb begin
      all_down = 1'b1;
      for (int i = 0; i < 8; i++) begin
         in_flat[12*i +: 12] = in_code[i];
         out_flat[12*i +: 12] = out_code[i];
         if (mode[i] != pwr_gnd_100k) begin
            all_down = 1'b0;
         end
      end
   end

   sequence seq_cmd(ods_cmd_t c);
      word_valid && word.command_nibble == c && !clr_low;
   endsequence

   sequence seq_quiet;
      !ld_low && !soft_load;
   endsequence

   a_clear_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      clr_low |=> in_flat == 96'h0 && out_flat == 96'h0 && all_down)
      else $error("clear input did not zero and power down");
   a_clear_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_clear) |=> in_flat == 96'h0 && out_flat == 96'h0 && all_down)
      else $error("clear command did not reset channels");
   a_nop_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(no_action_cmd) and seq_quiet |=> $stable(in_flat) && $stable(out_flat))
      else $error("no-op changed a register");
   a_write_in1: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_wr_in1) and seq_quiet
      |=> in_code[0] == $past(word.code_value) && $stable(out_flat))
      else $error("input register 1 write wrong");
   a_write_in8: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_wr_in8) and seq_quiet
      |=> in_code[7] == $past(word.code_value) && in_code[0] == $past(in_code[0]))
      else $error("input register 8 write wrong");
   a_write_all: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_wr_in_all) and seq_quiet
      |=> in_code[0] == $past(word.code_value) && in_code[7] == $past(word.code_value)
          && $stable(out_flat))
      else $error("write-all did not reach all input registers");
   a_thru_low: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_thru_lo) and seq_quiet
      |=> out_code[3] == $past(word.code_value) && out_code[4] == $past(out_code[4]))
      else $error("write-through of channels 1-4 wrong");
   a_strobe_pass: assert property (@(posedge mclk) disable iff (!rst_n)
      (ld_low && !clr_low) |=> out_flat == in_flat)
      else $error("load strobe low but outputs not transparent");
   a_soft_select: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_soft_load) and seq_quiet
      |=> out_code[0] == ($past(word.code_value[`ODS_SEL_LSB]) ? $past(in_code[0])
                                                               : $past(out_code[0])))
      else $error("software load ignored channel select");
   a_write_in2: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_wr_in2) and seq_quiet |=> in_code[1] == $past(word.code_value))
      else $error("input register 2 write wrong");
   a_write_in3: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_wr_in3) and seq_quiet
      |=> in_code[2] == $past(word.code_value) && $stable(out_flat))
      else $error("input register 3 write wrong");
   a_write_in5: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_wr_in5) and seq_quiet
      |=> in_code[4] == $past(word.code_value) && $stable(out_flat))
      else $error("input register 5 write wrong");
   a_thru_high: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_thru_hi) and seq_quiet
      |=> out_code[4] == $past(word.code_value) && in_code[7] == $past(word.code_value)
          && out_code[3] == $past(out_code[3]))
      else $error("write-through of channels 5-8 wrong");
   a_thru_every: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_thru_all) and seq_quiet
      |=> out_code[0] == $past(word.code_value) && out_code[7] == $past(word.code_value)
          && in_code[5] == $past(word.code_value))
      else $error("write-through of all channels wrong");
   a_soft_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      (soft_load && !clr_low) |=> out_flat == in_flat)
      else $error("register load pulse did not copy inputs to outputs");
   a_soft_select_last: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_cmd(cmd_soft_load) and seq_quiet
      |=> out_code[7] == ($past(word.code_value[`ODS_SEL_LSB + 7]) ? $past(in_code[7])
                                                                   : $past(out_code[7])))
      else $error("software load ignored select of channel 8");
   a_in_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (!word_valid && !clr_low) |=> $stable(in_flat))
      else $error("input register changed without a command");
   a_out_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (!word_valid && !clr_low && !ld_low && !soft_load)
      |=> $stable(out_flat))
      else $error("output code changed without a load");
endmodule

// File: dv/ods_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host serial master: 400 ns bit period, sclk idles low between frames
module ods_host_model (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   logic [31:0] rx;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      rx = '0;
   end
   // bits go out from w[31] downward; dout captured before each fall acts
   task automatic send(input logic [31:0] w, input int n);
      #17 cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         #200 din <= w[31-i];
         sclk <= 1'b1;
         #200 sclk <= 1'b0;
         rx = {rx[30:0], dout};
      end
      #200 cs_n <= 1'b1;
      // released line must not keep its last level
      din <= ~din;
      #200;
   endtask
   // clock pulses with the frame select high
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         #200 sclk <= 1'b1;
         #200 sclk <= 1'b0;
      end
   endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "ods_regs.svh"
module testbench import ods_pkg::*; ;
   logic mclk = 1'b0;
   logic rst_n, load_strobe_n, async_clear_n, sclk, cs_n, din, dout;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [3:0] wb_sel_i;
   logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   ods_chan_t chan [8];
   int error_cnt = 0;
   int tests_run = 0;
   int cyc_cnt = 0;
   always #25 mclk = ~mclk;
   ods_dac_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .load_strobe_n(load_strobe_n), .async_clear_n(async_clear_n),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .chan(chan));
   ods_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic chkch(input int i, input ods_mode_t m, input logic [11:0] c);
      chk({18'h0, chan[i]}, {18'h0, m, c});
   endtask
   task automatic frame(input ods_cmd_t c, input logic [11:0] v);
      i_host.send({c, v, 16'h0}, 16);
      repeat (10) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      load_strobe_n = 1'b1;
      async_clear_n = 1'b1;
      wb_adr_i = '0;
      wb_dat_i = '0;
      wb_sel_i = '0;
      wb_we_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'h000);
      rchk(`ODS_ADR_MODE, 32'h0000_FFFF);
      rchk(`ODS_ADR_CTRL, `ODS_CTRL_RESET);
      wb(1'b1, 8'h80, 32'h5);
      rchk(8'h80, 32'h0);
      wb(1'b1, `ODS_ADR_IN_BASE, 32'h123);
      rchk(`ODS_ADR_IN_BASE, 32'h0);
      $display("test reset done");
      frame(cmd_wr_in1, 12'hFFF);
      for (int i = 0; i < 8; i++) frame(ods_cmd_t'(4'(4'h2 + i)), 12'h3A0 + 12'(i));
      for (int i = 0; i < 8; i++) begin
         rchk(`ODS_ADR_IN_BASE + 8'(4 * i), 32'h3A0 + 32'(i));
         chkch(i, pwr_gnd_100k, 12'h000);
      end
      $display("test input writes done");
      frame(cmd_soft_load, 12'h550);
      for (int i = 0; i < 8; i++) begin
         chkch(i, pwr_gnd_100k, (i % 2 == 0) ? 12'h3A0 + 12'(i) : 12'h000);
      end
      $display("test soft load done");
      i_host.send({cmd_thru_all, 12'hEEE, 16'h0}, 15);
      repeat (10) @(posedge mclk);
      chkch(1, pwr_gnd_100k, 12'h000);
      rchk(`ODS_ADR_IN_BASE + 8'h04, 32'h3A1);
      wb(1'b1, `ODS_ADR_CTRL, 32'h0);
      frame(cmd_thru_all, 12'hDDD);
      chkch(1, pwr_gnd_100k, 12'h000);
      wb(1'b1, `ODS_ADR_CTRL, 32'h1);
      $display("test refused frames done");
      i_host.stray(3);
      frame(cmd_thru_lo, 12'h123);
      frame(cmd_thru_hi, 12'h456);
      for (int i = 0; i < 8; i++) begin
         chkch(i, pwr_gnd_100k, (i < 4) ? 12'h123 : 12'h456);
         rchk(`ODS_ADR_OUT_BASE + 8'(4 * i), (i < 4) ? 32'h123 : 32'h456);
      end
      frame(cmd_thru_all, 12'hABC);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'hABC);
      $display("test write through done");
      frame(cmd_wr_in_all, 12'h777);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'hABC);
      rchk(`ODS_ADR_IN_BASE + 8'h1C, 32'h777);
      load_strobe_n <= 1'b0;
      repeat (6) @(posedge mclk);
      load_strobe_n <= 1'b1;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'h777);
      frame(cmd_wr_in_all, 12'h321);
      wb(1'b1, `ODS_ADR_CTRL, 32'h3);
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'h321);
      $display("test load done");
      frame(cmd_power, 12'hFFC);
      rchk(`ODS_ADR_MODE, 32'h0);
      chkch(7, pwr_active, 12'h321);
      frame(cmd_power, 12'h0F4);
      frame(cmd_power, 12'h108);
      rchk(`ODS_ADR_MODE, 32'h0000_0255);
      chkch(4, pwr_gnd_1k, 12'h321);
      frame(cmd_power, 12'hF80);
      rchk(`ODS_ADR_MODE, 32'h0000_FFD5);
      frame(no_action_cmd, 12'hFFF);
      rchk(`ODS_ADR_MODE, 32'h0000_FFD5);
      chkch(0, pwr_hiz, 12'h321);
      rchk(`ODS_ADR_IN_BASE, 32'h321);
      $display("test power modes done");
      frame(cmd_clear, 12'h000);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'h000);
      rchk(`ODS_ADR_IN_BASE + 8'h10, 32'h0);
      rchk(`ODS_ADR_STAT, 32'h0000_0030);
      frame(cmd_power, 12'hFFC);
      frame(cmd_thru_all, 12'h5A5);
      async_clear_n <= 1'b0;
      repeat (4) @(posedge mclk);
      async_clear_n <= 1'b1;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 8; i++) chkch(i, pwr_gnd_100k, 12'h000);
      rchk(`ODS_ADR_IN_BASE + 8'h1C, 32'h0);
      $display("test clear done");
      // long frame: first word echoes on dout, last word is a no-op
      i_host.send({16'h39A6, 16'h0000}, 32);
      repeat (10) @(posedge mclk);
      chk({17'h0, i_host.rx[14:0]}, 32'h1CD3);
      rchk(`ODS_ADR_IN_BASE + 8'h04, 32'h0);
      $display("test echo done");
      conclude();
   end
endmodule
